// ===== qei_defs.vh
/*
 * Constants of the quadrature encoder block: register byte offsets, field positions,
 * reset values and mode codes.
 * Assumes inclusion by bare name from the block's Verilog files.
 */
`ifndef QEI_DEFS_VH
`define QEI_DEFS_VH

// ==========================================================
// Register byte offsets
`define QEI_ENC_CTRL_ADDR 8'h00
`define QEI_FLT_CTRL_ADDR 8'h04
`define QEI_POS_ADDR 8'h08
`define QEI_MAX_ADDR 8'h0C
`define QEI_STAT_ADDR 8'h10

// ==========================================================
// Encoder control fields
`define QEI_ERR_BIT 15
`define QEI_IDLE_STOP_BIT 13
`define QEI_DIR_BIT 11
`define QEI_MODE_HI 10
`define QEI_MODE_LO 8
`define QEI_IDX_RST_BIT 2
`define QEI_DIR_SRC_BIT 0

// ==========================================================
// Filter control fields
`define QEI_IMV_HI 10
`define QEI_IMV_LO 9
`define QEI_COUNT_ERROR_IRQ_DISABLE_BIT 8
`define QEI_FOUT_BIT 7
`define QEI_FCK_HI 6
`define QEI_FCK_LO 4

// ==========================================================
// Status register fields
`define QEI_ST_EVENT_BIT 0

// ==========================================================
// Mode codes
`define QEI_MODE_OFF 3'h0
`define QEI_MODE_TIMER 3'h1
`define QEI_MODE_X2_IDX 3'h4
`define QEI_MODE_X2_MAX 3'h5
`define QEI_MODE_X4_IDX 3'h6
`define QEI_MODE_X4_MAX 3'h7

// ==========================================================
// Reset values and filter timing
`define QEI_POS_RST 16'h0000
`define QEI_MAX_RST 16'hFFFF
`define QEI_FLT_STABLE 2'h3

`endif

// ===== qei_enc_model.sv
/*
 * Behavioural incremental encoder with index output, driving the phase and index pins.
 * Assumes its tasks are called just after a rising edge of clk_sys.
 */
`timescale 1ns/1ns
module qei_enc_model (
    input wire clk_sys, // System clock.
    output reg phase_a_input, // Phase A level.
    output reg phase_b_input, // Phase B level.
    output reg index_pulse_input // Index level.
);
    reg [1:0] st;
    initial begin
        st = 2'h0;
        phase_a_input = 1'b0;
        phase_b_input = 1'b0;
        index_pulse_input = 1'b0;
    end
    // One quadrature step; the order 00, 10, 11, 01 puts A ahead of B going forward.
    task step(input fwd);
        reg [1:0] n;
        begin
            case (st)
                2'h0: n = fwd ? 2'h2 : 2'h1;
                2'h2: n = fwd ? 2'h3 : 2'h0;
                2'h3: n = fwd ? 2'h1 : 2'h2;
                default: n = fwd ? 2'h0 : 2'h3;
            endcase
            st <= n;
            phase_a_input <= n[1];
            phase_b_input <= n[0];
            @(posedge clk_sys);
            @(posedge clk_sys);
        end
    endtask
    task index(input integer w);
        begin
            index_pulse_input <= 1'b1;
            repeat (w) @(posedge clk_sys);
            index_pulse_input <= 1'b0;
            @(posedge clk_sys);
        end
    endtask
endmodule // qei_enc_model

// ===== qei_filter.v
/*
 * Three-sample digital noise filter for one encoder channel.
 * Assumes the input is synchronous to clk_sys and a one-cycle sample tick.
 */
`timescale 1ns/1ns
`include "qei_defs.vh"

module qei_filter (
    input wire clk_sys, // System clock.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire tick, // Filter sample strobe.
    input wire din, // Raw channel level.
    output reg dout_q // Filtered channel level.
);
    reg [1:0] cnt_q;

    // ==========================================================
    // Output changes only after three agreeing samples.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q <= 2'h0;
            dout_q <= 1'b0;
        end else if (tick) begin
            if (din == dout_q) begin
                cnt_q <= 2'h0;
            end else if (cnt_q == `QEI_FLT_STABLE - 2'h1) begin
                dout_q <= din; // [RULE16]
                cnt_q <= 2'h0;
            end else begin
                cnt_q <= cnt_q + 2'h1;
            end
        end
    end
endmodule // qei_filter

// ===== qei_props.sv
/*
 * Concurrent checks on the ports of qei_top.
 * Assumes hready is the slave's own hreadyout; a shadow of two registers follows bus writes.
 */
`timescale 1ns/1ns
`include "qei_defs.vh"
module qei_props (
    input wire clk_sys, // Clock.
    input wire sys_rst, // Reset.
    input wire hsel, // Select.
    input wire [7:0] haddr, // Address.
    input wire [1:0] htrans, // Transfer type.
    input wire hwrite, // Write.
    input wire [31:0] hwdata, // Write data.
    input wire hready, // Bus ready.
    input wire [31:0] hrdata, // Read data.
    input wire hreadyout, // Slave ready.
    input wire hresp, // Response.
    input wire phase_a_input, // Phase A.
    input wire phase_b_input, // Phase B.
    input wire index_pulse_input, // Index.
    input wire cpu_sleep, // Sleep.
    input wire cpu_idle, // Idle.
    input wire count_direction_q, // Direction.
    input wire event_pulse_q // Event.
);
    reg wr_q;
    reg [7:0] wa_q;
    reg [15:0] ctrl_q;
    reg [15:0] flt_q;
    wire run = !cpu_sleep && !(cpu_idle && ctrl_q[`QEI_IDLE_STOP_BIT]);
    wire cnt = ctrl_q[`QEI_MODE_HI] && run && !flt_q[`QEI_FOUT_BIT];
    // ==========================================================
    // Shadow of the control registers, updated when a write lands.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            wr_q <= 1'b0;
            wa_q <= 8'h00;
            ctrl_q <= 16'h0000;
            flt_q <= 16'h0000;
        end else begin
            wr_q <= hsel && hready && htrans[1] && hwrite;
            wa_q <= haddr;
            if (wr_q && wa_q == `QEI_ENC_CTRL_ADDR) ctrl_q <= hwdata[15:0];
            if (wr_q && wa_q == `QEI_FLT_CTRL_ADDR) flt_q <= hwdata[15:0];
        end
    end
    // ==========================================================
    // Properties
    default clocking @(posedge clk_sys); endclocking
    default disable iff (sys_rst);
    property p_bus_okay; hreadyout && !hresp; endproperty
    a_bus_okay: assert property (p_bus_okay) else $error("slave stalled or answered an error");
    property p_unmapped;
        hsel && hready && htrans[1] && !hwrite && haddr >= 8'h14 |=> hrdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read returned data");
    property p_dir_fwd; cnt && $rose(phase_a_input) && !phase_b_input |=> count_direction_q; endproperty
    a_dir_fwd: assert property (p_dir_fwd) else $error("forward step not counted up");
    property p_dir_rev; cnt && $rose(phase_a_input) && phase_b_input |=> !count_direction_q; endproperty
    a_dir_rev: assert property (p_dir_rev) else $error("reverse step not counted down");
    property p_idx_evt;
        cnt && ctrl_q[10:8] == `QEI_MODE_X4_IDX && $rose(index_pulse_input) && phase_b_input == flt_q[`QEI_IMV_HI]
            && phase_a_input == flt_q[`QEI_IMV_LO] |=> event_pulse_q;
    endproperty
    a_idx_evt: assert property (p_idx_evt) else $error("matched index gave no event");
    property p_sleep; cpu_sleep |=> !event_pulse_q; endproperty
    a_sleep: assert property (p_sleep) else $error("event while asleep");
    property p_idle; cpu_idle && ctrl_q[`QEI_IDLE_STOP_BIT] |=> !event_pulse_q; endproperty
    a_idle: assert property (p_idle) else $error("event while idle-stopped");
    property p_flt;
        flt_q[`QEI_FOUT_BIT] && $rose(index_pulse_input) ##1 $fell(index_pulse_input) |=> !event_pulse_q [*6];
    endproperty
    a_flt: assert property (p_flt) else $error("filter passed a one-cycle glitch");
endmodule // qei_props
bind qei_top qei_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .phase_a_input(phase_a_input), .phase_b_input(phase_b_input), .index_pulse_input(index_pulse_input),
    .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle), .count_direction_q(count_direction_q), .event_pulse_q(event_pulse_q));

// ===== qei_top.v
/*
 * Quadrature encoder interface with AHB-Lite register slave: x2/x4 position counting,
 * index and maximum-count reset, count error checking, noise filters and timer mode.
 * Assumes pins synchronous to clk_sys and a single AHB-Lite master.
 */
// The AHB-Lite interface to the registers and the register offsets were left to the implementer.
//
// Contract
// RULE1: Modes 100/101 count each edge of phase A, direction from B.
// RULE2: Modes 110/111 count every edge of both phases.
// RULE3: Modes 100 and 110 reset the count on a qualified index.
// RULE4: Modes 101 and 111 reset the count on matching maximum count.
// RULE5: Count follows an internal direction from the phase relationship.
// RULE6: A leading B is forward (up); A lagging is reverse (down).
// RULE7: Index modes flag count error at FFFF or max+1 and raise event.
// RULE8: Filter control bit 8 suppresses the count error event.
// RULE9: After an error counting continues; natural wrap raises no event.
// RULE10: Error flag bit 15 is read/write, cleared only by software.
// RULE11: Index reset enable decides whether index resets the count.
// RULE12: In x4, index match needs B and A equal the match bits.
// RULE13: In x2, upper match bit picks phase, lower gives its level.
// RULE14: Index modes raise their event on index, not wrap.
// RULE15: Direction is readable at control bit 11 and on a pin.
// RULE16: Filters change only after three stable sample cycles.
// RULE17: Filter clock divides system clock by the 3-bit field. The code divides by 2 to the power of the field.
// RULE18: Filtered channels used only when enabled; off after reset.
// RULE19: Timer mode clocks from phase A, period is maximum count.
// RULE20: Direction source bit picks phase B pin or written bit.
// RULE21: Mode switches leave the count register untouched.
// RULE22: Sleep halts encoder and timer.
// RULE23: Idle halts counting only when the idle-stop bit is set.
// RULE24: Max-count modes wrap max to zero and zero to max.
`timescale 1ns/1ns
`include "qei_defs.vh"

module qei_top (
    input wire clk_sys, // System clock, 125 MHz.
    input wire sys_rst, // Asynchronous reset, active high.
    input wire hsel, // AHB slave select.
    input wire [7:0] haddr, // AHB byte address.
    input wire [1:0] htrans, // AHB transfer type.
    input wire hwrite, // AHB write.
    input wire [2:0] hsize, // AHB size.
    input wire [31:0] hwdata, // AHB write data.
    input wire hready, // AHB bus ready.
    output reg [31:0] hrdata, // AHB read data.
    output reg hreadyout, // AHB slave ready.
    output reg hresp, // AHB response, always OKAY.
    input wire phase_a_input, // Encoder phase A.
    input wire phase_b_input, // Encoder phase B.
    input wire index_pulse_input, // Encoder index.
    input wire cpu_sleep, // CPU sleep state.
    input wire cpu_idle, // CPU idle state.
    output reg count_direction_q, // Count direction pin.
    output reg event_pulse_q // Module event, one cycle.
);
    // ==========================================================
    // Registers.
    reg count_error_flag_q;
    reg idle_stop_bit_q;
    reg dir_bit_q;
    reg [2:0] encoder_mode_select_q;
    reg index_reset_enable_q;
    reg direction_source_select_q;
    reg [1:0] index_match_state_q;
    reg count_error_irq_disable_q;
    reg filter_output_enable_q;
    reg [2:0] filter_clock_divide_q;
    reg [15:0] position_count_q;
    reg [15:0] maximum_count_q;
    reg event_seen_q;
    reg wr_pend_q;
    reg [7:0] wr_addr_q;

    // ==========================================================
    // Filter clock divider: tick every 2^field system clocks.
    reg [7:0] div_q;
    wire flt_tick;
    assign flt_tick = ((div_q & ((8'h01 << filter_clock_divide_q) - 8'h01)) == 8'h00); // [RULE17]
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 8'h00;
        end else begin
            div_q <= div_q + 8'h01;
        end
    end

    wire fa, fb, fi;
    qei_filter u_fa (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick(flt_tick), .din(phase_a_input), .dout_q(fa));
    qei_filter u_fb (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick(flt_tick), .din(phase_b_input), .dout_q(fb));
    qei_filter u_fi (.clk_sys(clk_sys), .sys_rst(sys_rst), .tick(flt_tick), .din(index_pulse_input),
        .dout_q(fi));

    wire a_in, b_in, i_in;
    assign a_in = filter_output_enable_q ? fa : phase_a_input; // [RULE18]
    assign b_in = filter_output_enable_q ? fb : phase_b_input; // [RULE18]
    assign i_in = filter_output_enable_q ? fi : index_pulse_input; // [RULE18]

    // ==========================================================
    // Edge detection and quadrature decode.
    reg a_q, b_q, i_q;
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            a_q <= 1'b0;
            b_q <= 1'b0;
            i_q <= 1'b0;
        end else begin
            a_q <= a_in;
            b_q <= b_in;
            i_q <= i_in;
        end
    end

    wire a_edge, b_edge, idx_rise;
    assign a_edge = a_in ^ a_q;
    assign b_edge = b_in ^ b_q;
    assign idx_rise = i_in & ~i_q;

    wire is_x2, is_x4, is_qei, is_idx_mode, is_max_mode, is_timer;
    assign is_x2 = (encoder_mode_select_q == `QEI_MODE_X2_IDX) || (encoder_mode_select_q == `QEI_MODE_X2_MAX);
    assign is_x4 = (encoder_mode_select_q == `QEI_MODE_X4_IDX) || (encoder_mode_select_q == `QEI_MODE_X4_MAX);
    assign is_qei = is_x2 | is_x4;
    assign is_idx_mode = (encoder_mode_select_q == `QEI_MODE_X2_IDX) ||
        (encoder_mode_select_q == `QEI_MODE_X4_IDX); // [RULE3]
    assign is_max_mode = (encoder_mode_select_q == `QEI_MODE_X2_MAX) ||
        (encoder_mode_select_q == `QEI_MODE_X4_MAX); // [RULE4]
    assign is_timer = (encoder_mode_select_q == `QEI_MODE_TIMER);

    // Forward when A leads B: after an A edge, A differs from B; after a B edge, they match.
    reg qdir;
    always @* begin
        if (a_edge) begin
            qdir = a_in ^ b_in; // [RULE6]
        end else if (b_edge) begin
            qdir = ~(a_in ^ b_in); // [RULE6]
        end else begin
            qdir = count_direction_q;
        end
    end

    wire run;
    assign run = ~cpu_sleep & ~(cpu_idle & idle_stop_bit_q); // [RULE22] [RULE23]

    reg step;
    reg up;
    always @* begin
        step = 1'b0;
        up = count_direction_q;
        if (is_x2) begin
            step = a_edge; // [RULE1]
            up = qdir; // [RULE5]
        end else if (is_x4) begin
            step = a_edge | b_edge; // [RULE2]
            up = qdir; // [RULE5]
        end else if (is_timer) begin
            step = a_in & ~a_q; // [RULE19]
            up = direction_source_select_q ? b_in : dir_bit_q; // [RULE20]
        end
        step = step & run;
    end

    // Index qualification against the match bits.
    reg idx_match;
    always @* begin
        if (is_x4) begin
            idx_match = (b_in == index_match_state_q[1]) && (a_in == index_match_state_q[0]); // [RULE12]
        end else begin
            idx_match = (index_match_state_q[1] ? b_in : a_in) == index_match_state_q[0]; // [RULE13]
        end
    end
    wire idx_hit;
    assign idx_hit = run & is_idx_mode & idx_rise & idx_match;

    // ==========================================================
    // Position counter next value and events.
    reg [15:0] pos_d;
    reg err_hit;
    reg evt;
    always @* begin
        pos_d = position_count_q;
        err_hit = 1'b0;
        evt = 1'b0;
        if (idx_hit) begin
            evt = 1'b1; // [RULE14]
            if (index_reset_enable_q) begin
                pos_d = `QEI_POS_RST; // [RULE11]
            end
        end else if (step) begin
            if (is_max_mode || is_timer) begin
                if (up && position_count_q == maximum_count_q) begin
                    pos_d = `QEI_POS_RST; // [RULE4] [RULE24]
                    evt = 1'b1; // [RULE19]
                end else if (!up && position_count_q == 16'h0000) begin
                    pos_d = maximum_count_q; // [RULE24]
                    evt = 1'b1;
                end else begin
                    pos_d = up ? position_count_q + 16'h0001 : position_count_q - 16'h0001;
                end
            end else begin
                pos_d = up ? position_count_q + 16'h0001 : position_count_q - 16'h0001; // [RULE9]
                if (is_idx_mode && (pos_d == 16'hFFFF || {1'b0, pos_d} == {1'b0, maximum_count_q} + 17'h00001)) begin
                    err_hit = 1'b1; // [RULE7]
                    evt = ~count_error_irq_disable_q; // [RULE8]
                end
            end
        end
    end

    // ==========================================================
    // AHB-Lite slave: zero-wait reads, writes land in the data phase.
    wire addr_ok;
    assign addr_ok = hsel & hready & htrans[1];
    wire [15:0] wd;
    assign wd = hwdata[15:0];

    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend_q <= addr_ok & hwrite;
            wr_addr_q <= haddr;
            hrdata <= 32'h00000000;
            if (addr_ok && !hwrite) begin
                if (haddr == `QEI_ENC_CTRL_ADDR) begin
                    hrdata <= {16'h0000, count_error_flag_q, 1'b0, idle_stop_bit_q, 1'b0,
                        count_direction_q, encoder_mode_select_q, 5'h00, index_reset_enable_q, 1'b0,
                        direction_source_select_q}; // [RULE15]
                end else if (haddr == `QEI_FLT_CTRL_ADDR) begin
                    hrdata <= {21'h000000, index_match_state_q, count_error_irq_disable_q,
                        filter_output_enable_q, filter_clock_divide_q, 4'h0};
                end else if (haddr == `QEI_POS_ADDR) begin
                    hrdata <= {16'h0000, position_count_q};
                end else if (haddr == `QEI_MAX_ADDR) begin
                    hrdata <= {16'h0000, maximum_count_q};
                end else if (haddr == `QEI_STAT_ADDR) begin
                    hrdata <= {31'h00000000, event_seen_q};
                end
            end
        end
    end

    wire wr_ctrl, wr_flt, wr_pos, wr_max, wr_stat;
    assign wr_ctrl = wr_pend_q && (wr_addr_q == `QEI_ENC_CTRL_ADDR);
    assign wr_flt = wr_pend_q && (wr_addr_q == `QEI_FLT_CTRL_ADDR);
    assign wr_pos = wr_pend_q && (wr_addr_q == `QEI_POS_ADDR);
    assign wr_max = wr_pend_q && (wr_addr_q == `QEI_MAX_ADDR);
    assign wr_stat = wr_pend_q && (wr_addr_q == `QEI_STAT_ADDR);

    // ==========================================================
    // Register and counter update.
    always @(posedge clk_sys or posedge sys_rst) begin
        if (sys_rst) begin
            count_error_flag_q <= 1'b0;
            idle_stop_bit_q <= 1'b0; // [RULE23]
            dir_bit_q <= 1'b0;
            encoder_mode_select_q <= `QEI_MODE_OFF;
            index_reset_enable_q <= 1'b0;
            direction_source_select_q <= 1'b0;
            index_match_state_q <= 2'h0;
            count_error_irq_disable_q <= 1'b0;
            filter_output_enable_q <= 1'b0; // [RULE18]
            filter_clock_divide_q <= 3'h0;
            position_count_q <= `QEI_POS_RST;
            maximum_count_q <= `QEI_MAX_RST;
            event_seen_q <= 1'b0;
            count_direction_q <= 1'b0;
            event_pulse_q <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                idle_stop_bit_q <= wd[`QEI_IDLE_STOP_BIT];
                dir_bit_q <= wd[`QEI_DIR_BIT];
                encoder_mode_select_q <= wd[`QEI_MODE_HI:`QEI_MODE_LO]; // [RULE21]
                index_reset_enable_q <= wd[`QEI_IDX_RST_BIT];
                direction_source_select_q <= wd[`QEI_DIR_SRC_BIT];
            end
            if (wr_flt) begin
                index_match_state_q <= wd[`QEI_IMV_HI:`QEI_IMV_LO];
                count_error_irq_disable_q <= wd[`QEI_COUNT_ERROR_IRQ_DISABLE_BIT];
                filter_output_enable_q <= wd[`QEI_FOUT_BIT];
                filter_clock_divide_q <= wd[`QEI_FCK_HI:`QEI_FCK_LO];
            end
            if (err_hit) begin
                count_error_flag_q <= 1'b1; // [RULE7] [RULE10]
            end else if (wr_ctrl) begin
                count_error_flag_q <= wd[`QEI_ERR_BIT]; // [RULE10]
            end
            if (wr_pos) begin
                position_count_q <= wd;
            end else begin
                position_count_q <= pos_d;
            end
            if (wr_max) begin
                maximum_count_q <= wd;
            end
            if (evt) begin
                event_seen_q <= 1'b1;
            end else if (wr_stat && wd[`QEI_ST_EVENT_BIT]) begin
                event_seen_q <= 1'b0;
            end
            event_pulse_q <= evt;
            if (is_qei) begin
                count_direction_q <= qdir; // [RULE15]
            end else if (is_timer) begin
                count_direction_q <= up;
            end
        end
    end
endmodule // qei_top

// ===== testbench.sv
/*
 * Self-checking testbench of qei_top with an encoder model on the pins.
 * Assumes a single AHB-Lite master whose hready is the slave's hreadyout.
 */
`timescale 1ns/1ns
`include "qei_defs.vh"
module testbench;
    reg clk_sys, sys_rst, hsel, hwrite, cpu_sleep, cpu_idle;
    reg [7:0] haddr;
    reg [1:0] htrans;
    reg [2:0] hsize;
    reg [31:0] hwdata, rd, lf;
    reg [15:0] ep, mx;
    wire [31:0] hrdata;
    wire hreadyout, hresp, pa, pb, pi, dir, evt;
    integer error_cnt = 0, n_compared = 0, n_evt = 0, e0, m;
    qei_top DUT (.clk_sys(clk_sys), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .phase_a_input(pa), .phase_b_input(pb), .index_pulse_input(pi), .cpu_sleep(cpu_sleep), .cpu_idle(cpu_idle),
        .count_direction_q(dir), .event_pulse_q(evt));
    qei_enc_model enc (.clk_sys(clk_sys), .phase_a_input(pa), .phase_b_input(pb), .index_pulse_input(pi));
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) if (evt === 1'b1) n_evt = n_evt + 1;
    function [31:0] lfsr(input [31:0] s);
        lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    // Next expected count; max-count modes wrap between the maximum and zero.
    function [15:0] adv(input [15:0] e, input f, input mm);
        if (mm) adv = f ? (e == mx ? 16'h0000 : e + 16'h0001) : (e == 16'h0000 ? mx : e - 16'h0001);
        else adv = f ? e + 16'h0001 : e - 16'h0001;
    endfunction
    task ahb(input w, input [7:0] a, input [31:0] d);
        integer t;
        begin
            t = 0;
            hsel <= 1;
            htrans <= 2'h2;
            haddr <= a;
            hwrite <= w;
            hsize <= 3'h2;
            do begin @(posedge clk_sys); t = t + 1; end while (hreadyout !== 1'b1 && t < 50);
            hsel <= 0;
            htrans <= 2'h0;
            hwdata <= d;
            do begin @(posedge clk_sys); t = t + 1; end while (hreadyout !== 1'b1 && t < 100);
            rd = hrdata;
            if (t >= 100) error_cnt = error_cnt + 1;
        end
    endtask
    task chk(input [31:0] g, input [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                error_cnt = error_cnt + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask
    task rdc(input [7:0] a, input [31:0] e);
        begin ahb(0, a, 0); chk(rd, e); end
    endtask
    // Steps the encoder; x2 counts only when phase A changes.
    task mv(input f, input x4, input mm);
        reg o;
        begin o = enc.st[1]; enc.step(f); if (x4 || o !== enc.st[1]) ep = adv(ep, f, mm); end
    endtask
    task home;
        while (enc.st != 2'h0) enc.step(1'b1);
    endtask
    task finish_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, error_cnt);
            if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
            else $display("Some tests failed");
            $finish;
        end
    endtask
    initial begin
        #400000;
        error_cnt = error_cnt + 1;
        finish_test;
    end
    initial begin
        {sys_rst, hsel, hwrite, cpu_sleep, cpu_idle, haddr, htrans, hwdata} = {1'b1, 46'h0};
        hsize = 3'h2;
        lf = 32'hE2B2E80F;
        repeat (4) @(posedge clk_sys);
        sys_rst <= 0;
        @(posedge clk_sys);
        rdc(`QEI_POS_ADDR, `QEI_POS_RST);
        rdc(`QEI_MAX_ADDR, `QEI_MAX_RST);
        rdc(`QEI_ENC_CTRL_ADDR, 0);
        rdc(`QEI_FLT_CTRL_ADDR, 0);
        ahb(1, 8'h14, 32'hFFFFFFFF);
        rdc(8'h14, 0);
        $display("reset test done");
        for (m = 0; m < 2; m = m + 1) begin
            lf = lfsr(lf);
            mx = {12'h000, lf[3:0]} | 16'h0003;
            ahb(1, `QEI_MAX_ADDR, mx);
            ahb(1, `QEI_POS_ADDR, 0);
            ep = 0;
            ahb(1, `QEI_ENC_CTRL_ADDR, (m == 0 ? `QEI_MODE_X4_MAX : `QEI_MODE_X2_MAX) << 8);
            repeat (40) begin lf = lfsr(lf); mv(lf[0], m == 0, 1); end
            rdc(`QEI_POS_ADDR, ep);
            if (m == 0) rdc(`QEI_ENC_CTRL_ADDR, 32'h0700 | {lf[0], 11'h0});
            if (m == 0) chk({31'h0, dir}, {31'h0, lf[0]});
        end
        $display("count test done");
        home;
        for (m = 0; m < 2; m = m + 1) begin
            ahb(1, `QEI_ENC_CTRL_ADDR, (m == 0 ? `QEI_MODE_X4_IDX : `QEI_MODE_X2_IDX) << 8 | 32'h4);
            ahb(1, `QEI_FLT_CTRL_ADDR, 32'h200);
            ahb(1, `QEI_POS_ADDR, 16'h1234);
            enc.index(2);
            rdc(`QEI_POS_ADDR, 16'h1234);
            ahb(1, `QEI_FLT_CTRL_ADDR, 0);
            ahb(1, `QEI_STAT_ADDR, 1);
            e0 = n_evt;
            enc.index(2);
            rdc(`QEI_POS_ADDR, 0);
            chk(n_evt - e0, 1);
            rdc(`QEI_STAT_ADDR, 1);
            ahb(1, `QEI_ENC_CTRL_ADDR, (m == 0 ? `QEI_MODE_X4_IDX : `QEI_MODE_X2_IDX) << 8);
            ahb(1, `QEI_POS_ADDR, 16'h1234);
            enc.index(2);
            rdc(`QEI_POS_ADDR, 16'h1234);
        end
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0600);
        mx = 16'h0100;
        ahb(1, `QEI_MAX_ADDR, mx);
        ahb(1, `QEI_POS_ADDR, 1);
        ep = 1;
        e0 = n_evt;
        mv(0, 1, 0);
        mv(0, 1, 0);
        rdc(`QEI_ENC_CTRL_ADDR, 32'h8600);
        mv(1, 1, 0);
        rdc(`QEI_POS_ADDR, ep);
        chk(n_evt - e0, 1);
        rdc(`QEI_ENC_CTRL_ADDR, 32'h8E00);
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0600);
        rdc(`QEI_ENC_CTRL_ADDR, 32'h0E00);
        ahb(1, `QEI_FLT_CTRL_ADDR, 32'h100);
        ahb(1, `QEI_POS_ADDR, mx);
        e0 = n_evt;
        mv(1, 1, 0);
        rdc(`QEI_ENC_CTRL_ADDR, 32'h8E00);
        chk(n_evt - e0, 0);
        $display("index and error test done");
        home;
        ahb(1, `QEI_FLT_CTRL_ADDR, 0);
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0900);
        ahb(1, `QEI_POS_ADDR, 16'h10);
        repeat (8) enc.step(1);
        rdc(`QEI_POS_ADDR, 16'h12);
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0101);
        repeat (4) enc.step(0);
        enc.step(1);
        rdc(`QEI_POS_ADDR, 16'h12);
        home;
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0900);
        ahb(1, `QEI_MAX_ADDR, 16'h13);
        e0 = n_evt;
        repeat (8) enc.step(1);
        chk(n_evt > e0, 1);
        ahb(1, `QEI_POS_ADDR, 16'h55);
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0700);
        rdc(`QEI_POS_ADDR, 16'h55);
        $display("timer test done");
        mx = 16'h13;
        ahb(1, `QEI_POS_ADDR, 0);
        ep = 0;
        cpu_sleep <= 1;
        repeat (4) enc.step(1);
        cpu_sleep <= 0;
        rdc(`QEI_POS_ADDR, 0);
        cpu_idle <= 1;
        mv(1, 1, 1);
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h2700);
        repeat (4) enc.step(1);
        cpu_idle <= 0;
        rdc(`QEI_POS_ADDR, ep);
        $display("sleep and idle test done");
        home;
        ahb(1, `QEI_ENC_CTRL_ADDR, 32'h0604);
        ahb(1, `QEI_FLT_CTRL_ADDR, 32'hA0);
        ahb(1, `QEI_POS_ADDR, 16'h77);
        enc.index(1);
        enc.index(4);
        repeat (20) @(posedge clk_sys);
        rdc(`QEI_POS_ADDR, 16'h77);
        enc.index(40);
        repeat (20) @(posedge clk_sys);
        rdc(`QEI_POS_ADDR, 0);
        $display("filter test done");
        finish_test;
    end
endmodule // testbench
